// ==== src/ref_pkg.sv ====
// Constants, register map and carrier types of the residual earth fault stage
// Notes on behaviour
// R1: Coarse, sensitive and calculated residual sources accepted.
// R2: Magnitude selectable RMS, TRMS (32 harmonics), peak-to-peak; the calculated input always uses its sample peak.
// R3: Peak-to-peak magnitude comes from raw samples.
// R4: All measurement signals refresh on 5 ms base.
// R5: Eight parameter sets, one common selector source.
// R6: Blocking and set selection change at runtime.
// R7: Instant, definite-time or inverse-time curve operation.
// R8: Saturation check keeps start and operate working.
// R9: Fixed processing order from selection to outputs.
// R10: START, TRIP, BLOCKED outputs for I/O and logic.
// R11: Time-stamped ON/OFF event per output edge.
// R12: Instant mode START and TRIP share stamp.
// R13: Event time stamps have 1 ms resolution.
// R14: Clearable cumulative START, TRIP, BLOCKED counters.
// R15: Pre-fault value is 20 ms average, 20 ms back.
// R16: Configuration setting picks the residual input channel.
// R17: Pick-up above threshold, release below 97 percent.
// R18: Blocked pick-up reports BLOCKED instead of START.
// R19: Input select 1 coarse, 2 sensitive, 3 calculated.
// R20: Forced status 0 normal, 1 start, 2 trip, 3 blocked.
// R21: Definite time trips after delay, clears with START.
package ref_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TBASE_MS = 5;
  localparam int STAMP_MS = 1;
  localparam int PREFAULT_MS = 20;
  localparam int TBASE_CYC = TBASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STAMP_CYC = STAMP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PREFAULT_TICKS = PREFAULT_MS / TBASE_MS;
  localparam int HIST_DEPTH = 2 * PREFAULT_TICKS;
  localparam int RESET_RATIO_PCT = 97;
  localparam int FULL_PCT = 100;
  localparam int HARMONICS = 32;
  localparam logic [15:0] SAT_LEVEL = 16'h7f00;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PADDR = 8'h04;
  localparam logic [7:0] OFS_PDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CNT_START = 8'h10;
  localparam logic [7:0] OFS_CNT_TRIP = 8'h14;
  localparam logic [7:0] OFS_CNT_BLOCK = 8'h18;
  localparam logic [7:0] OFS_CNT_CLR = 8'h1c;
  localparam logic [7:0] OFS_PREFAULT = 8'h20;
  localparam logic [7:0] OFS_MAG = 8'h24;
  localparam logic [7:0] OFS_LAST_EVT = 8'h28;
  localparam logic [7:0] OFS_TIME = 8'h2c;

  // Control field positions and reset
  localparam int CTRL_INSEL_LSB = 0;
  localparam int CTRL_MAGSEL_LSB = 2;
  localparam int CTRL_FORCE_EN_BIT = 4;
  localparam int CTRL_FORCE_LSB = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0005;

  // Encodings
  localparam logic [1:0] IN_COARSE = 2'h1;
  localparam logic [1:0] IN_SENS = 2'h2;
  localparam logic [1:0] IN_CALC = 2'h3;
  localparam logic [1:0] MAG_RMS = 2'h1;
  localparam logic [1:0] MAG_TRMS = 2'h2;
  localparam logic [1:0] MAG_PP = 2'h3;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [1:0] OP_INSTANT = 2'h0;
  localparam logic [1:0] OP_DT = 2'h1;
  localparam logic [1:0] OP_IDMT = 2'h2;
  localparam logic [1:0] CURVE_IEC = 2'h0;
  localparam logic [1:0] CURVE_ANSI = 2'h1;
  localparam logic [1:0] CURVE_CUSTOM = 2'h2;

  // Parameter set memory
  localparam int SET_COUNT = 8;
  localparam int MEM_DEPTH = 2 * SET_COUNT;

  // Even word of a parameter set
  typedef struct packed {
    logic [7:0] custom_add;
    logic [3:0] rsvd;
    logic [1:0] curve;
    logic [1:0] op_mode;
    logic [15:0] threshold;
  } ref_set_t;

  // Event word posted to the shared event buffer
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [2:0] changed;
    logic [2:0] level;
  } ref_evt_t;

  // Measurement inputs from the front end
  typedef struct packed {
    logic [15:0] coarse_rms;
    logic [15:0] coarse_trms;
    logic signed [15:0] coarse_raw;
    logic [15:0] sens_rms;
    logic [15:0] sens_trms;
    logic signed [15:0] sens_raw;
    logic signed [15:0] phase_a;
    logic signed [15:0] phase_b;
    logic signed [15:0] phase_c;
  } ref_meas_t;
endpackage

// ==== src/ref_param_mem.sv ====
// Parameter set storage with one write port and two registered read ports
`timescale 1ns/1ps
module ref_param_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  // Read ports
  input wire logic [3:0] raddr_a,
  input wire logic [3:0] raddr_b,
  output logic [31:0] rdata_a,
  output logic [31:0] rdata_b
);
  logic [31:0] mem [ref_pkg::MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule

// ==== src/ref_stage.sv ====
// Residual earth fault protection stage with APB register access
`timescale 1ns/1ps
module ref_stage #(
  parameter int TBASE_CYC = ref_pkg::TBASE_CYC,
  parameter int STAMP_CYC = ref_pkg::STAMP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements, one new sample set per sample_valid
  input wire ref_pkg::ref_meas_t meas,
  input wire logic sample_valid,
  // Runtime control
  input wire logic block_in,
  input wire logic [2:0] active_set,
  // Stage outputs
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  // Event stream
  output logic evt_valid,
  output ref_pkg::ref_evt_t evt
);
  // Decoding
  function automatic logic [15:0] abs16(input logic signed [17:0] v);
    logic [17:0] a;
    a = v[17] ? 18'(-v) : 18'(v);
    abs16 = (a > 18'h0ffff) ? 16'hffff : a[15:0];
  endfunction

  // Time bases
  logic [31:0] tb_cnt_q;
  logic [31:0] ms_cnt_q;
  logic [31:0] stamp_q;
  wire tick_5ms = (tb_cnt_q == 32'(TBASE_CYC - 1));
  wire tick_1ms = (ms_cnt_q == 32'(STAMP_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt_q <= 32'h0;
      ms_cnt_q <= 32'h0;
      stamp_q <= 32'h0;
    end else begin
      // R4: 5 ms base
      tb_cnt_q <= tick_5ms ? 32'h0 : tb_cnt_q + 32'h1;
      // R13: ms stamp
      ms_cnt_q <= tick_1ms ? 32'h0 : ms_cnt_q + 32'h1;
      if (tick_1ms) begin
        stamp_q <= stamp_q + 32'h1;
      end
    end
  end

  // APB access decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd_ok = (paddr == ref_pkg::OFS_CTRL) || (paddr == ref_pkg::OFS_PADDR) ||
               (paddr == ref_pkg::OFS_PDATA) || (paddr == ref_pkg::OFS_STATUS) ||
               (paddr == ref_pkg::OFS_CNT_START) || (paddr == ref_pkg::OFS_CNT_TRIP) ||
               (paddr == ref_pkg::OFS_CNT_BLOCK) || (paddr == ref_pkg::OFS_CNT_CLR) ||
               (paddr == ref_pkg::OFS_PREFAULT) || (paddr == ref_pkg::OFS_MAG) ||
               (paddr == ref_pkg::OFS_LAST_EVT) || (paddr == ref_pkg::OFS_TIME);
  wire wr_ctrl = wr && (paddr == ref_pkg::OFS_CTRL);
  wire wr_paddr = wr && (paddr == ref_pkg::OFS_PADDR);
  wire wr_pdata = wr && (paddr == ref_pkg::OFS_PDATA);
  wire wr_clr = wr && (paddr == ref_pkg::OFS_CNT_CLR);

  logic [31:0] ctrl_q;
  logic [3:0] pidx_q;
  logic [31:0] plast_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ref_pkg::CTRL_RESET;
      pidx_q <= 4'h0;
      plast_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {25'h0, pwdata[6:0]};
      end
      if (wr_paddr) begin
        pidx_q <= pwdata[3:0];
      end
      if (wr_pdata) begin
        plast_q <= pwdata;
      end
    end
  end

  // R16: channel from a setting
  wire [1:0] in_sel = ctrl_q[ref_pkg::CTRL_INSEL_LSB +: 2];
  wire [1:0] mag_sel = ctrl_q[ref_pkg::CTRL_MAGSEL_LSB +: 2];
  wire force_en = ctrl_q[ref_pkg::CTRL_FORCE_EN_BIT];
  wire [1:0] force_st = ctrl_q[ref_pkg::CTRL_FORCE_LSB +: 2];

  // R5: set memory, active set picked by one common input
  logic [31:0] set_word;
  logic [31:0] delay_word;
  ref_param_mem u_mem (
    .clk(pclk),
    .we(wr_pdata),
    .waddr(pidx_q),
    .wdata(pwdata),
    .raddr_a({active_set, 1'b0}),
    .raddr_b({active_set, 1'b1}),
    .rdata_a(set_word),
    .rdata_b(delay_word)
  );
  ref_pkg::ref_set_t set_cfg;
  assign set_cfg = ref_pkg::ref_set_t'(set_word);

  // R3: raw sample extremes over each 5 ms window
  logic signed [15:0] c_max_q, c_min_q, s_max_q, s_min_q;
  logic [15:0] calc_pk_q;
  logic sat_q;
  wire [15:0] calc_now = abs16(18'(meas.phase_a) + 18'(meas.phase_b) + 18'(meas.phase_c));
  wire [15:0] c_abs = abs16(18'(meas.coarse_raw));
  wire [15:0] s_abs = abs16(18'(meas.sens_raw));
  // R8: full-scale raw sample marks saturation
  wire sat_now = (in_sel == ref_pkg::IN_SENS) ? (s_abs >= ref_pkg::SAT_LEVEL) :
                 (c_abs >= ref_pkg::SAT_LEVEL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_max_q <= 16'sh8000;
      c_min_q <= 16'sh7fff;
      s_max_q <= 16'sh8000;
      s_min_q <= 16'sh7fff;
      calc_pk_q <= 16'h0;
      sat_q <= 1'b0;
    end else if (tick_5ms) begin
      c_max_q <= 16'sh8000;
      c_min_q <= 16'sh7fff;
      s_max_q <= 16'sh8000;
      s_min_q <= 16'sh7fff;
      calc_pk_q <= 16'h0;
      sat_q <= 1'b0;
    end else if (sample_valid) begin
      if (meas.coarse_raw > c_max_q) c_max_q <= meas.coarse_raw;
      if (meas.coarse_raw < c_min_q) c_min_q <= meas.coarse_raw;
      if (meas.sens_raw > s_max_q) s_max_q <= meas.sens_raw;
      if (meas.sens_raw < s_min_q) s_min_q <= meas.sens_raw;
      if (calc_now > calc_pk_q) calc_pk_q <= calc_now;
      if (sat_now) sat_q <= 1'b1;
    end
  end

  // R1: three residual sources; R2: RMS, TRMS or peak-to-peak
  wire [15:0] c_pp = abs16(18'(c_max_q) - 18'(c_min_q));
  wire [15:0] s_pp = abs16(18'(s_max_q) - 18'(s_min_q));
  // TRMS values come from the front end with all 32 harmonics folded in
  wire [15:0] c_sel = (mag_sel == ref_pkg::MAG_PP) ? c_pp :
                      (mag_sel == ref_pkg::MAG_TRMS) ? meas.coarse_trms : meas.coarse_rms;
  wire [15:0] s_sel = (mag_sel == ref_pkg::MAG_PP) ? s_pp :
                      (mag_sel == ref_pkg::MAG_TRMS) ? meas.sens_trms : meas.sens_rms;
  // R19: input select codes
  wire [15:0] sel_mag = (in_sel == ref_pkg::IN_SENS) ? s_sel :
                        (in_sel == ref_pkg::IN_CALC) ? calc_pk_q : c_sel;
  wire [15:0] sel_pp_half = ((in_sel == ref_pkg::IN_SENS) ? s_pp : c_pp) >> 1;
  // R8: a clipped RMS underreads, so the sample peak stands in for it
  wire [15:0] proc_mag = (sat_q && in_sel != ref_pkg::IN_CALC && sel_pp_half > sel_mag) ?
                         sel_pp_half : sel_mag;

  // R9: magnitude latched at the 5 ms program cycle, then compared
  logic [15:0] mag_q;
  logic pickup_q;
  logic [15:0] hist_q [ref_pkg::HIST_DEPTH];
  wire [22:0] mag_pct = 23'(mag_q) * 23'(ref_pkg::FULL_PCT);
  wire [22:0] rel_pct = 23'(set_cfg.threshold) * 23'(ref_pkg::RESET_RATIO_PCT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_q <= 16'h0;
      pickup_q <= 1'b0;
    end else if (tick_5ms) begin
      mag_q <= proc_mag;
    end else begin
      // R17: pick-up with 97 percent release
      if (mag_q > set_cfg.threshold) begin
        pickup_q <= 1'b1;
      end else if (mag_pct < rel_pct) begin
        pickup_q <= 1'b0;
      end
    end
  end

  // R15: history of 5 ms values for the pre-fault average
  genvar gi;
  generate
    for (gi = 0; gi < ref_pkg::HIST_DEPTH; gi++) begin : g_hist
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hist_q[gi] <= 16'h0;
        end else if (tick_5ms) begin
          hist_q[gi] <= (gi == 0) ? proc_mag : hist_q[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate
  wire [17:0] pre_sum = 18'(hist_q[4]) + 18'(hist_q[5]) + 18'(hist_q[6]) + 18'(hist_q[7]);
  wire [15:0] pre_avg = pre_sum[17:2];

  // R18: block check decides START or BLOCKED; R6: read live every cycle
  wire start_raw = pickup_q && !block_in;
  wire block_raw = pickup_q && block_in;

  // R7: instant, definite or inverse time
  logic [31:0] dly_q;
  logic trip_hold_q;
  wire [16:0] excess = 17'(mag_q) - 17'(set_cfg.threshold);
  // Inside the release band the excess is negative and must not count
  wire [15:0] ex_pos = excess[16] ? 16'h0 : excess[15:0];
  wire [31:0] ex_lin = {16'h0, ex_pos};
  wire [31:0] ex_sq = 32'(ex_pos) * 32'(ex_pos) >> 8;
  wire [31:0] idmt_inc = (set_cfg.curve == ref_pkg::CURVE_ANSI) ? ex_sq :
                         (set_cfg.curve == ref_pkg::CURVE_CUSTOM) ?
                         ex_lin + 32'(set_cfg.custom_add) : ex_lin;
  wire instant = (set_cfg.op_mode == ref_pkg::OP_INSTANT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= 32'h0;
      trip_hold_q <= 1'b0;
    end else if (!start_raw) begin
      // R21: trip ends with START
      dly_q <= 32'h0;
      trip_hold_q <= 1'b0;
    end else if (tick_1ms && !trip_hold_q) begin
      if (set_cfg.op_mode == ref_pkg::OP_IDMT) begin
        dly_q <= dly_q + idmt_inc;
        trip_hold_q <= (dly_q + idmt_inc) >= delay_word;
      end else begin
        // R21: definite delay in ms
        dly_q <= dly_q + 32'h1;
        trip_hold_q <= (dly_q + 32'h1) >= delay_word;
      end
    end
  end

  // R20: forced status overrides; R12: instant START and TRIP together
  wire trip_raw = start_raw && (instant || trip_hold_q);
  wire [2:0] lvl_d = force_en ?
    {force_st == ref_pkg::COND_BLOCKED, force_st == ref_pkg::COND_TRIP,
     force_st == ref_pkg::COND_START || force_st == ref_pkg::COND_TRIP} :
    {block_raw, trip_raw, start_raw};
  logic [2:0] lvl_q;

  // R10: registered outputs for I/O and logic
  assign start_o = lvl_q[0];
  assign trip_o = lvl_q[1];
  assign blocked_o = lvl_q[2];
  wire [2:0] rise = lvl_d & ~lvl_q;

  // R11: one event word carries every simultaneous edge with one stamp
  logic [15:0] cnt_q [3];
  logic [15:0] prefault_q;
  ref_pkg::ref_evt_t last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 3'h0;
      evt_valid <= 1'b0;
      evt <= '0;
      last_q <= '0;
      prefault_q <= 16'h0;
    end else begin
      lvl_q <= lvl_d;
      evt_valid <= (lvl_d != lvl_q);
      if (lvl_d != lvl_q) begin
        // R13: ms stamp
        evt <= '{stamp_ms: stamp_q, changed: lvl_d ^ lvl_q, level: lvl_d};
        last_q <= '{stamp_ms: stamp_q, changed: lvl_d ^ lvl_q, level: lvl_d};
      end
      // R15: capture on START or TRIP onset
      if (rise[0] || rise[1]) begin
        prefault_q <= pre_avg;
      end
    end
  end

  // R14: counters, an edge in the clear cycle still counts
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[gi] <= 16'h0;
        end else if (rise[gi]) begin
          cnt_q[gi] <= (wr_clr && pwdata[gi]) ? 16'h1 : cnt_q[gi] + 16'h1;
        end else if (wr_clr && pwdata[gi]) begin
          cnt_q[gi] <= 16'h0;
        end
      end
    end
  endgenerate

  // Status view
  wire [1:0] cond = lvl_q[2] ? ref_pkg::COND_BLOCKED : lvl_q[1] ? ref_pkg::COND_TRIP :
                    lvl_q[0] ? ref_pkg::COND_START : ref_pkg::COND_NORMAL;
  wire [31:0] status = {25'h0, sat_q, active_set, pickup_q, cond};

  // APB read mux; zero wait states, unmapped offsets error
  wire [31:0] rd_mux =
    (paddr == ref_pkg::OFS_CTRL) ? ctrl_q :
    (paddr == ref_pkg::OFS_PADDR) ? {28'h0, pidx_q} :
    (paddr == ref_pkg::OFS_PDATA) ? plast_q :
    (paddr == ref_pkg::OFS_STATUS) ? status :
    (paddr == ref_pkg::OFS_CNT_START) ? {16'h0, cnt_q[0]} :
    (paddr == ref_pkg::OFS_CNT_TRIP) ? {16'h0, cnt_q[1]} :
    (paddr == ref_pkg::OFS_CNT_BLOCK) ? {16'h0, cnt_q[2]} :
    (paddr == ref_pkg::OFS_PREFAULT) ? {16'h0, prefault_q} :
    (paddr == ref_pkg::OFS_MAG) ? {16'h0, mag_q} :
    (paddr == ref_pkg::OFS_LAST_EVT) ? {last_q.stamp_ms[25:0], last_q.changed, last_q.level} :
    (paddr == ref_pkg::OFS_TIME) ? stamp_q : 32'h0;
  assign pready = 1'b1;
  assign pslverr = acc && !rd_ok;
  assign prdata = (acc && !pwrite) ? rd_mux : 32'h0;
endmodule

// ==== dv/ref_stage_assertions.sv ====
// Concurrent checks on the ports of the residual earth fault stage
`timescale 1ns/1ps
module ref_stage_assertions #(
  parameter int TBASE_CYC = 50,
  parameter int STAMP_CYC = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus side
  input wire logic pslverr,
  // Runtime control
  input wire logic block_in,
  // Stage outputs
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire logic evt_valid,
  input wire ref_pkg::ref_evt_t evt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] cyc_q;
  logic [31:0] last_q;
  logic [31:0] d_stamp;
  logic [2:0] outs;
  assign outs = {blocked_o, trip_o, start_o};
  assign d_stamp = evt.stamp_ms - last_q;

  // Cycles and stamp of the previous event, for the resolution check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 32'h0;
      last_q <= 32'h0;
    end else if (evt_valid) begin
      cyc_q <= 32'h1;
      last_q <= evt.stamp_ms;
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

  a_start_excl: assert property (!(start_o && blocked_o))
    else $error("start and blocked both active");
  a_block_cause: assert property ($rose(blocked_o) |-> $past(block_in))
    else $error("blocked rose without blocking input");
  a_start_cause: assert property ($rose(start_o) |-> !$past(block_in))
    else $error("start rose while blocking input active");
  a_trip_start: assert property (trip_o |-> start_o)
    else $error("trip active without start");
  a_evt_edge: assert property ($changed(outs) |->
    evt_valid && evt.changed == (outs ^ $past(outs)) && evt.level == outs)
    else $error("output change without matching event word");
  a_evt_only: assert property (evt_valid |-> $changed(outs))
    else $error("event posted without output change");
  a_evt_hold: assert property (!evt_valid |-> $stable(evt))
    else $error("event word changed without a new event");
  // Stamp steps must match elapsed time to one tick either way
  a_stamp_res: assert property (evt_valid |-> d_stamp * STAMP_CYC <= cyc_q + STAMP_CYC
    && d_stamp * STAMP_CYC + STAMP_CYC >= cyc_q)
    else $error("event stamp does not follow elapsed time");

  c_instant: cover property ($rose(start_o) && trip_o);
  c_trip_late: cover property ($rose(trip_o) && $past(start_o));
  c_blocked: cover property ($rose(blocked_o));
  c_refused: cover property (pslverr);
endmodule

bind ref_stage ref_stage_assertions #(.TBASE_CYC(TBASE_CYC), .STAMP_CYC(STAMP_CYC))
  ref_stage_assertions_i (.pclk(pclk), .presetn(presetn), .pslverr(pslverr),
  .block_in(block_in), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
  .evt_valid(evt_valid), .evt(evt));

// ==== dv/ref_front_model.sv ====
// Behavioural analog front end feeding residual current samples
`timescale 1ns/1ps
module ref_front_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scenario control: which source carries current, and how much
  input wire logic [1:0] src,
  input wire logic [15:0] lvl,
  // Sample stream
  output ref_pkg::ref_meas_t meas,
  output logic sample_valid
);
  logic [2:0] div_q;
  logic pol_q;
  localparam logic [15:0] CLIP = 16'h4000;
  logic signed [15:0] raw;
  logic [15:0] rms;
  // Raw samples swing both ways, peak-to-peak twice the level
  assign raw = pol_q ? -$signed(lvl) : $signed(lvl);
  // Saturated transformer: the RMS path underreads above the clip level
  assign rms = (lvl > CLIP) ? CLIP : lvl;
  assign sample_valid = presetn && (div_q == 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
      pol_q <= 1'b0;
    end else begin
      div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      pol_q <= pol_q ^ sample_valid;
    end
  end

  // Idle sources carry no current, not stale values
  always_comb begin
    meas = '0;
    if (src == 2'h1) begin
      meas.coarse_rms = rms;
      meas.coarse_trms = rms;
      meas.coarse_raw = raw;
    end
    if (src == 2'h2) begin
      meas.sens_rms = rms;
      meas.sens_trms = rms;
      meas.sens_raw = raw;
    end
    if (src == 2'h3) begin
      meas.phase_a = raw;
    end
  end
endmodule

// ==== dv/ref_stage_tb_top.sv ====
// Self-checking bench of the residual earth fault stage
`timescale 1ns/1ps
module ref_stage_tb_top;
  localparam int TB = 50;
  localparam int ST = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ref_pkg::ref_meas_t meas;
  logic sample_valid;
  logic block_in = 1'b0;
  logic [2:0] active_set = 3'h0;
  logic start_o, trip_o, blocked_o;
  logic evt_valid;
  ref_pkg::ref_evt_t evt;
  logic [1:0] src = 2'h1;
  logic [15:0] lvl = 16'h0000;
  logic [2:0] outs;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int n_tests = 0;
  int n;
  assign outs = {blocked_o, trip_o, start_o};

  ref_front_model ref_front_model_i (.pclk(pclk), .presetn(presetn), .src(src), .lvl(lvl),
    .meas(meas), .sample_valid(sample_valid));
  ref_stage #(.TBASE_CYC(TB), .STAMP_CYC(ST)) ref_stage_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
    .sample_valid(sample_valid), .block_in(block_in), .active_set(active_set),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .evt_valid(evt_valid),
    .evt(evt));

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on one output, sampled after the edge has settled
  task automatic wait_out(input int b, input logic v, input int lim);
    n = 0;
    while (outs[b] !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic set_in(input logic [1:0] s, input logic [15:0] l);
    @(posedge pclk);
    src <= s;
    lvl <= l;
  endtask

  function automatic logic [31:0] cfg(input int s);
    logic [1:0] op;
    op = (s == 0) ? 2'h0 : ((s > 1 && s < 5) ? 2'h2 : 2'h1);
    return {8'h10, 4'h0, 2'((s > 1 && s < 5) ? s - 2 : 0), op, 16'h0100};
  endfunction

  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ref_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0000_0005);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    // Parameter memory is not reset, so every word is written
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, ref_pkg::OFS_PADDR, 32'(2 * s));
      apb(1'b1, ref_pkg::OFS_PDATA, cfg(s));
      apb(1'b1, ref_pkg::OFS_PADDR, 32'(2 * s + 1));
      apb(1'b1, ref_pkg::OFS_PDATA, (s == 1) ? 32'h3 : 32'h900);
    end
    set_in(2'h1, 16'h0080);
    repeat (12 * TB) @(posedge pclk);
    set_in(2'h1, 16'h0400);
    wait_out(0, 1'b1, 4 * TB);
    check({29'h0, outs}, 32'h3);
    apb(1'b0, ref_pkg::OFS_PREFAULT, 32'h0);
    check(rd, 32'h80);
    // Hysteresis: 250 holds, 248 is below 97 percent of 256
    set_in(2'h1, 16'h00fa);
    repeat (4 * TB) @(posedge pclk);
    check({31'h0, start_o}, 32'h1);
    set_in(2'h1, 16'h00f8);
    wait_out(0, 1'b0, 4 * TB);
    check({31'h0, start_o}, 32'h0);
    set_in(2'h1, 16'h0100);
    repeat (4 * TB) @(posedge pclk);
    check({31'h0, start_o}, 32'h0);
    apb(1'b1, ref_pkg::OFS_CNT_CLR, 32'h7);
    @(posedge pclk);
    block_in <= 1'b1;
    set_in(2'h1, 16'h0400);
    wait_out(2, 1'b1, 4 * TB);
    check({29'h0, outs}, 32'h4);
    @(posedge pclk);
    block_in <= 1'b0;
    wait_out(0, 1'b1, 4 * TB);
    check({29'h0, outs}, 32'h3);
    set_in(2'h1, 16'h0000);
    wait_out(0, 1'b0, 4 * TB);
    apb(1'b0, ref_pkg::OFS_LAST_EVT, 32'h0);
    check({26'h0, rd[5:0]}, 32'h18);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 8'(ref_pkg::OFS_CNT_START + 4 * k), 32'h0);
      check(rd, 32'h1);
    end
    apb(1'b1, ref_pkg::OFS_CNT_CLR, 32'h7);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 8'(ref_pkg::OFS_CNT_START + 4 * k), 32'h0);
      check(rd, 32'h0);
    end
    // Every source against every magnitude kind
    for (int i = 1; i < 4; i++) begin
      for (int m = 1; m < 4; m++) begin
        apb(1'b1, ref_pkg::OFS_CTRL, 32'(m * 4 + i));
        set_in(2'(i), 16'h0400);
        wait_out(0, 1'b1, 4 * TB);
        check({31'h0, start_o}, 32'h1);
        set_in(2'(i), 16'h0000);
        wait_out(0, 1'b0, 4 * TB);
      end
    end
    apb(1'b1, ref_pkg::OFS_CTRL, 32'h5);
    set_in(2'h2, 16'h0400);
    repeat (4 * TB) @(posedge pclk);
    check({31'h0, start_o}, 32'h0);
    set_in(2'h1, 16'h0000);
    // Definite time: three milliseconds from start to trip
    @(posedge pclk);
    active_set <= 3'h1;
    set_in(2'h1, 16'h0400);
    wait_out(0, 1'b1, 4 * TB);
    check({31'h0, trip_o}, 32'h0);
    wait_out(1, 1'b1, 10 * ST);
    check({31'h0, n >= 2 * ST && n <= 3 * ST + 1}, 32'h1);
    set_in(2'h1, 16'h0000);
    wait_out(0, 1'b0, 4 * TB);
    check({31'h0, trip_o}, 32'h0);
    for (int s = 2; s < 5; s++) begin
      @(posedge pclk);
      active_set <= 3'(s);
      set_in(2'h1, 16'h0400);
      wait_out(0, 1'b1, 4 * TB);
      check({31'h0, trip_o}, 32'h0);
      wait_out(1, 1'b1, 20 * ST);
      check({31'h0, trip_o}, 32'h1);
      set_in(2'h1, 16'h0000);
      wait_out(0, 1'b0, 4 * TB);
    end
    // Forced blocked is paired with the blocking input to keep causes consistent
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      block_in <= (c == 3);
      apb(1'b1, ref_pkg::OFS_CTRL, 32'h15 | 32'(c << 5));
      repeat (4) @(posedge pclk);
      #1;
      check({29'h0, outs}, (c == 3) ? 32'h4 : 32'((1 << c) - 1));
      apb(1'b0, ref_pkg::OFS_STATUS, 32'h0);
      check({30'h0, rd[1:0]}, 32'(c));
    end
    apb(1'b1, ref_pkg::OFS_CTRL, 32'h5);
    @(posedge pclk);
    block_in <= 1'b0;
    repeat (4) @(posedge pclk);
    // Clipped RMS under saturation, the sample peak restores the level
    set_in(2'h1, 16'h7f00);
    repeat (3 * TB) @(posedge pclk);
    apb(1'b0, ref_pkg::OFS_MAG, 32'h0);
    check(rd, 32'h7f00);
    print_verdict();
  end
endmodule
